// File: hms_motor_model.sv
// motor, switch and encoder model facing the homing sequencer
// assumes one clock; the carriage moves cmd.speed counts per cycle while run is high
`default_nettype none
module hms_motor_model
   import hms_pkg::*;
#(
   parameter int HOME_LO = 200, // first count where the home switch is made
   parameter int HOME_HI = 300, // last count where the home switch is made
   parameter int NLIM_AT = -1000, // negative overtravel at and below this
   parameter int PLIM_AT = 1000 // positive overtravel at and above this
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command from the sequencer
   input var hms_cmd_t cmd,
   // bench places the carriage while idle
   input wire logic load,
   input wire logic signed [31:0] load_pos,
   // pins back to the sequencer
   output logic home_switch_input,
   output logic negative_overtravel_input,
   output logic positive_overtravel_input,
   output logic index_pulse_input,
   output logic signed [31:0] pos
);
   timeunit 1ns;
   timeprecision 1ps;
   // position integrator; no ramp, so a stop lands a few counts past the edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pos <= '0;
      end else if (load) begin
         pos <= load_pos;
      end else if (cmd.run) begin
         pos <= cmd.dir_pos ? pos + $signed(cmd.speed) : pos - $signed(cmd.speed);
      end
   end
   // ideal switches: levels follow position with no bounce
   assign home_switch_input = (pos >= HOME_LO) && (pos <= HOME_HI);
   assign negative_overtravel_input = pos <= NLIM_AT;
   assign positive_overtravel_input = pos >= PLIM_AT;
   // index is four counts wide, so a creep pass holds it for four cycles
   assign index_pulse_input = pos[5:0] < 6'h04;
endmodule
`default_nettype wire

// File: hms_pkg.sv
// package of the switch-based homing sequencer: codes, profiles, carriers
// assumes one 200 MHz clock and a motion profile that ramps on its own
`default_nettype none
package hms_pkg;
   // control word values that arm and start homing
   localparam logic [7:0] HMS_CW_ENABLED = 8'h0f;
   localparam logic [7:0] HMS_CW_START = 8'h1f;
   localparam int unsigned HMS_CW_HOMING_BIT = 4;
   // method codes
   localparam logic [3:0] HMS_M_IDX_NEG = 4'h0;
   localparam logic [3:0] HMS_M_NLIM = 4'h1;
   localparam logic [3:0] HMS_M_PLIM = 4'h2;
   localparam logic [3:0] HMS_M_HS_A = 4'h3;
   localparam logic [3:0] HMS_M_HS_B = 4'h4;
   localparam logic [3:0] HMS_M_HS_C = 4'h5;
   localparam logic [3:0] HMS_M_HS_D = 4'h6;
   localparam logic [3:0] HMS_M_HS_LIM = 4'h7;
   localparam logic [3:0] HMS_M_RISE = 4'h8;
   localparam logic [3:0] HMS_M_LAST = 4'h9;
   // input slots: home switch, negative and positive overtravel, index
   localparam int unsigned HMS_NIN = 4;
   localparam int unsigned HMS_SYNC = 3;
   localparam logic [1:0] HMS_IN_HOME = 2'h0;
   localparam logic [1:0] HMS_IN_NLIM = 2'h1;
   localparam logic [1:0] HMS_IN_PLIM = 2'h2;
   localparam logic [1:0] HMS_IN_IDX = 2'h3;
   localparam int unsigned HMS_SPD_W = 32;
   typedef enum logic [2:0] {HMS_IDLE, HMS_SEARCH, HMS_SLOW1, HMS_SLOW2} hms_phase_t;
   // configuration supplied by the controller
   typedef struct packed {
      logic [3:0] method;
      logic [HMS_SPD_W-1:0] high_speed;
      logic [HMS_SPD_W-1:0] low_speed;
      logic [HMS_SPD_W-1:0] decel;
   } hms_cfg_t;
   // command toward the motion profile
   typedef struct packed {
      logic run;
      logic dir_pos;
      logic [HMS_SPD_W-1:0] speed;
      logic [HMS_SPD_W-1:0] decel;
   } hms_cmd_t;
   // one method as a path through the phases
   typedef struct packed {
      logic ok;
      logic [1:0] sel;
      logic ifast;
      logic idir;
      logic afast;
      logic adir;
      logic s1dir;
      logic s1end;
      logic s2dir;
      logic s2idx;
   } hms_prof_t;
   // all state of the sequencer
   typedef struct packed {
      hms_phase_t ph;
      logic [HMS_NIN-1:0][HMS_SYNC-1:0] sync;
      logic [HMS_NIN-1:0] lvl;
      logic [7:0] cw_prev;
      hms_prof_t prof;
      logic rev;
      logic wfall;
      logic fast;
      logic dir;
      logic busy;
      logic done;
      logic err;
      hms_cmd_t cmd;
   } hms_st_t;
   localparam hms_st_t HMS_ST_RST = '0;
endpackage
`default_nettype wire

// File: hms_sequencer.sv
// homing sequencer: drives direction and speed, stops on switch edges or on the index pulse
// assumes switch and index pins are asynchronous, control word is on clk
`default_nettype none
// Function
// - limit ahead during search reverses, stays fast
// - index method: fast, slow at rise, index stop
// - after limit reversal, rise turns negative slow
// - switch active at start: negative slow, index
// - negative limit home: fast, reverse, stop fall
// - negative limit active: positive slow, stop fall
// - positive limit home: fast, reverse, stop fall
// - positive limit active: negative slow, stop fall
// - switch method: positive fast, negative slow, fall
// - switch inactive: positive slow, stop at rise
// - switch active: negative fast, reverse, rise stop
// - mirrored: negative fast, positive slow, fall stop
// - switch inactive: negative slow, stop at rise
// - switch active: positive fast, reverse, rise stop
// - limit-aware switch method: as positive switch method
// - after limit reversal keep negative, stop fall
// - rise negative slow, fall positive, rise stop
// - active start: negative slow, reverse, rise stop
// - rise keeps positive slow, fall negative, rise
// - reversed: rise back to positive slow, then same
// - active start: positive slow, reverse, rise stop
module hms_sequencer
   import hms_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // controller side
   input wire logic [7:0] control_word,
   input var hms_cfg_t cfg,
   // switch and encoder pins
   input wire logic home_switch_input,
   input wire logic negative_overtravel_input,
   input wire logic positive_overtravel_input,
   input wire logic index_pulse_input,
   // toward motion profile and status
   output var hms_cmd_t cmd,
   output logic busy,
   output logic done,
   output logic err
);
   hms_st_t q; // registered state
   hms_st_t d; // next state
   logic [HMS_NIN-1:0] pins; // raw pins in slot order
   logic [HMS_NIN-1:0] nlvl; // filtered level after this edge
   logic [HMS_NIN-1:0] rise; // filtered level going active
   logic [HMS_NIN-1:0] fall; // filtered level going inactive
   logic start; // control word step that starts homing
   logic s_rise; // rise of the watched signal
   logic s_fall; // fall of the watched signal
   logic lim_hit; // limit ahead of travel reached
   logic hold; // homing bit still set
   hms_prof_t np; // profile of the requested method

   // method table, one entry per method code; the low byte holds, from
   // the top: ifast idir afast adir s1dir s1end s2dir s2idx
   // ifast idir: first motion when the watched signal starts inactive
   // afast adir: fast first motion when it starts active (else creep)
   // s1dir: creep direction while the watched signal is active
   // s1end: the first fall opens a second creep leg instead of stopping
   // s2dir s2idx: direction of that leg; stop on index rather than rise
   // a code outside the table returns ok low, and the start logic
   // refuses it, so a typo in the method never moves the carriage
   function automatic hms_prof_t hms_profile(input logic [3:0] m);
      hms_prof_t p;
      p = '0;
      unique case (m)
         HMS_M_IDX_NEG: p = {1'b1, HMS_IN_HOME, 8'h85};
         HMS_M_NLIM: p = {1'b1, HMS_IN_NLIM, 8'h88};
         HMS_M_PLIM: p = {1'b1, HMS_IN_PLIM, 8'hc0};
         HMS_M_HS_A: p = {1'b1, HMS_IN_HOME, 8'hc0};
         HMS_M_HS_B: p = {1'b1, HMS_IN_HOME, 8'h22};
         HMS_M_HS_C: p = {1'b1, HMS_IN_HOME, 8'h88};
         HMS_M_HS_D: p = {1'b1, HMS_IN_HOME, 8'h30};
         HMS_M_HS_LIM: p = {1'b1, HMS_IN_HOME, 8'hc0};
         HMS_M_RISE: p = {1'b1, HMS_IN_HOME, 8'hc6};
         HMS_M_LAST: p = {1'b1, HMS_IN_HOME, 8'hcc};
         default: p = '0; // unknown code: refused at start
      endcase
      return p;
   endfunction

   assign pins = {index_pulse_input, positive_overtravel_input,
                  negative_overtravel_input, home_switch_input};

   // per input: a change counts only when stages two and three agree,
   // so a one-cycle glitch never reaches the phase logic
   for (genvar i = 0; i < HMS_NIN; i++) begin : g_in
      assign nlvl[i] = (q.sync[i][2] == q.sync[i][1]) ? q.sync[i][2] : q.lvl[i];
      assign rise[i] = nlvl[i] & ~q.lvl[i];
      assign fall[i] = ~nlvl[i] & q.lvl[i];
   end

   // start only on the exact step enabled -> start; the controller is
   // expected to make that step, any other path leaves us idle
   assign start = (q.cw_prev == HMS_CW_ENABLED) && (control_word == HMS_CW_START);
   assign hold = control_word[HMS_CW_HOMING_BIT];
   assign np = hms_profile(cfg.method);
   assign s_rise = rise[q.prof.sel];
   assign s_fall = fall[q.prof.sel];
   // limit reversal only for switch methods: in limit methods the
   // limit itself is the home signal
   assign lim_hit = (q.prof.sel == HMS_IN_HOME) &&
                    (q.dir ? rise[HMS_IN_PLIM] : rise[HMS_IN_NLIM]);

   // next state
   always_comb begin
      d = q;
      // synchroniser chain: stage one is read only by stage two
      for (int i = 0; i < HMS_NIN; i++) begin
         d.sync[i] = {q.sync[i][1:0], pins[i]};
      end
      d.lvl = nlvl;
      d.cw_prev = control_word;
      unique case (q.ph)
         HMS_IDLE: begin
            if (start) begin
               d.prof = np;
               d.rev = 1'b0;
               d.done = 1'b0;
               d.err = !np.ok;
               d.busy = np.ok;
               if (!np.ok) begin
                  // unknown method: refuse and stay idle
                  d.ph = HMS_IDLE;
               end else if (nlvl[np.sel]) begin
                  // watched signal active at start
                  if (np.afast) begin
                     d.ph = HMS_SEARCH;
                     d.dir = np.adir;
                     d.fast = 1'b1;
                     d.wfall = 1'b1;
                  end else begin
                     d.ph = HMS_SLOW1;
                     d.dir = np.s1dir;
                     d.fast = 1'b0;
                  end
               end else if (np.ifast) begin
                  d.ph = HMS_SEARCH;
                  d.dir = np.idir;
                  d.fast = 1'b1;
                  d.wfall = 1'b0;
               end else begin
                  d.ph = HMS_SLOW2;
                  d.dir = np.s2dir;
                  d.fast = 1'b0;
               end
            end
         end
         HMS_SEARCH: begin
            if (!q.wfall && s_rise) begin
               // slow direction is fixed by the method, whether or not
               // a limit turned us round
               d.ph = HMS_SLOW1;
               d.dir = q.prof.s1dir;
               d.fast = 1'b0;
            end else if (q.wfall && s_fall) begin
               d.ph = HMS_SLOW2;
               d.dir = q.prof.s2dir;
               d.fast = 1'b0;
            end else if (lim_hit) begin
               d.dir = !q.dir;
               d.rev = 1'b1;
            end
         end
         HMS_SLOW1: begin
            if (s_fall) begin
               if (q.prof.s1end) begin
                  d.ph = HMS_SLOW2;
                  d.dir = q.prof.s2dir;
               end else begin
                  d.ph = HMS_IDLE;
                  d.busy = 1'b0;
                  d.done = 1'b1;
               end
            end
         end
         HMS_SLOW2: begin
            // stop on index or on the returning rise
            if (q.prof.s2idx ? rise[HMS_IN_IDX] : s_rise) begin
               d.ph = HMS_IDLE;
               d.busy = 1'b0;
               d.done = 1'b1;
            end
         end
      endcase
      // controller dropped the homing bit: abort without done; a stop
      // found in the same cycle has already cleared d.busy, so the done
      // flag it sets survives instead of being lost to the abort
      if (d.busy && !hold) begin
         d.ph = HMS_IDLE;
         d.busy = 1'b0;
         d.done = 1'b0;
      end
      if (!d.busy) begin
         d.fast = 1'b0;
      end
      // command computed from next state so outputs match the phase
      d.cmd.run = d.busy;
      d.cmd.dir_pos = d.dir;
      d.cmd.speed = !d.busy ? '0 : (d.fast ? cfg.high_speed : cfg.low_speed);
      d.cmd.decel = cfg.decel;
   end

   // state register; reset loads constants only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= HMS_ST_RST;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign cmd = q.cmd;
   assign busy = q.busy;
   assign done = q.done;
   assign err = q.err;

   // checks run on the one clock and sleep while reset is held
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_start_only_cw: assert property ($rose(q.busy) |-> $past(start))
      else $error("homing started without control word step");
   chk_limit_reverse: assert property ((q.ph == HMS_SEARCH && lim_hit && !s_rise && !s_fall
      && hold) |=> (q.cmd.dir_pos != $past(q.cmd.dir_pos)) && q.fast)
      else $error("no reversal at limit");
   chk_index_stop: assert property ((q.ph == HMS_SLOW2 && q.prof.s2idx
      && rise[HMS_IN_IDX] && hold) |=> q.done && !q.cmd.run)
      else $error("index did not stop motion");
   chk_idx_slow_neg: assert property ((q.busy && q.prof.s2idx && q.ph != HMS_SEARCH)
      |-> !q.cmd.dir_pos && q.cmd.speed == $past(cfg.low_speed))
      else $error("index method slow phase not negative low");
   chk_search_fast: assert property ((q.ph == HMS_SEARCH)
      |-> q.cmd.run && q.cmd.speed == $past(cfg.high_speed))
      else $error("search not at high speed");
   chk_nlim_stop: assert property ((q.ph == HMS_SLOW1 && q.prof.sel == HMS_IN_NLIM
      && q.cmd.dir_pos && fall[HMS_IN_NLIM] && hold) |=> q.done && !q.busy)
      else $error("negative limit fall did not stop");
   chk_plim_dir: assert property ((q.ph == HMS_SLOW1 && q.prof.sel == HMS_IN_PLIM)
      |-> !q.cmd.dir_pos)
      else $error("positive limit creep not negative");
   chk_rise_stop: assert property ((q.ph == HMS_SLOW2 && !q.prof.s2idx
      && s_rise && hold) |=> q.done ##1 !q.cmd.run)
      else $error("rise did not stop creep");
   chk_edge_filter: assert property (rise[HMS_IN_HOME] |->
      $past(home_switch_input, 2) && $past(home_switch_input, 3) && !q.lvl[HMS_IN_HOME])
      else $error("home edge taken from unstable sync");
   chk_slow_after_rise: assert property ((q.ph == HMS_SEARCH && !q.wfall && s_rise
      && hold) |=> q.ph == HMS_SLOW1 && q.cmd.dir_pos == q.prof.s1dir)
      else $error("wrong creep direction after rise");
   chk_fall_stop: assert property ((q.ph == HMS_SLOW1 && !q.prof.s1end
      && s_fall && hold) |=> q.done && !q.cmd.run)
      else $error("fall did not stop creep");
   chk_creep_turn: assert property ((q.ph == HMS_SLOW1 && q.prof.s1end
      && !q.prof.s2idx && s_fall && hold) |=> q.ph == HMS_SLOW2 && !q.fast
      && q.cmd.dir_pos != $past(q.cmd.dir_pos))
      else $error("no creep reversal at fall");
   chk_abort_stop: assert property ((q.busy && !hold) |=>
      !q.busy && !q.cmd.run && q.cmd.speed == '0)
      else $error("homing bit low did not stop motion");

   // main scenarios: index stop, limit reversal, two-leg creep, refusal
   cov_index_home: cover property (q.ph == HMS_SLOW2 && q.prof.s2idx ##1 q.done);
   cov_reversed_home: cover property (q.rev && q.ph == HMS_SLOW1);
   cov_double_rise: cover property (q.prof.s1end && !q.prof.s2idx && q.ph == HMS_SLOW2);
   cov_bad_method: cover property ($rose(q.err));
   cov_limit_reverse: cover property (q.ph == HMS_SEARCH && lim_hit ##1 q.rev);
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the homing sequencer against a moving carriage
// assumes the motor model above; speeds are tiny so that runs stay short
`default_nettype none
module tb_top
   import hms_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // one homing case: method, placement, first motion, stop window
   typedef struct packed {
      logic [3:0] method;
      int start;
      logic dir0;
      logic fast0;
      logic [2:0] win;
   } hms_tb_row_t;
   logic clk, rst, load;
   logic [7:0] control_word;
   hms_cfg_t cfg;
   hms_cmd_t cmd;
   logic busy, done, err, home, nlim, plim, idx;
   logic signed [31:0] load_pos, pos;
   int bad_count = 0, total_checks = 0, cycles = 0;
   // stop windows in counts, from where each edge sits plus filter delay
   int win_lo [0:6] = '{185, -1000, 990, 190, 200, 300, 290};
   int win_hi [0:6] = '{196, -990, 1000, 200, 210, 310, 300};
   hms_tb_row_t rows [0:23] = '{
      '{4'h0, 500, 1'b0, 1'b1, 3'h0},
      '{4'h0, 0, 1'b0, 1'b1, 3'h0},
      '{4'h0, 250, 1'b0, 1'b0, 3'h0},
      '{4'h1, 0, 1'b0, 1'b1, 3'h1},
      '{4'h1, -1005, 1'b1, 1'b0, 3'h1},
      '{4'h2, 0, 1'b1, 1'b1, 3'h2},
      '{4'h2, 1005, 1'b0, 1'b0, 3'h2},
      '{4'h3, 0, 1'b1, 1'b1, 3'h3},
      '{4'h3, 250, 1'b0, 1'b0, 3'h3},
      '{4'h4, 0, 1'b1, 1'b0, 3'h4},
      '{4'h4, 250, 1'b0, 1'b1, 3'h4},
      '{4'h5, 500, 1'b0, 1'b1, 3'h5},
      '{4'h5, 250, 1'b1, 1'b0, 3'h5},
      '{4'h6, 500, 1'b0, 1'b0, 3'h6},
      '{4'h6, 250, 1'b1, 1'b1, 3'h6},
      '{4'h7, 0, 1'b1, 1'b1, 3'h3},
      '{4'h7, 500, 1'b1, 1'b1, 3'h3},
      '{4'h7, 250, 1'b0, 1'b0, 3'h3},
      '{4'h8, 0, 1'b1, 1'b1, 3'h4},
      '{4'h8, 500, 1'b1, 1'b1, 3'h4},
      '{4'h8, 250, 1'b0, 1'b0, 3'h4},
      '{4'h9, 0, 1'b1, 1'b1, 3'h6},
      '{4'h9, 500, 1'b1, 1'b1, 3'h6},
      '{4'h9, 250, 1'b1, 1'b0, 3'h6}
   };
   hms_sequencer hms_sequencer_i (.clk(clk), .rst(rst), .control_word(control_word), .cfg(cfg),
      .home_switch_input(home), .negative_overtravel_input(nlim),
      .positive_overtravel_input(plim), .index_pulse_input(idx), .cmd(cmd), .busy(busy),
      .done(done), .err(err));
   hms_motor_model hms_motor_model_i (.clk(clk), .rst(rst), .cmd(cmd), .load(load),
      .load_pos(load_pos), .home_switch_input(home), .negative_overtravel_input(nlim),
      .positive_overtravel_input(plim), .index_pulse_input(idx), .pos(pos));
   // free-running clock, 5 ns period
   always #2.5 clk = ~clk;
   // hang guard: well above the roughly 4000 cycles the cases need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         $display("ERROR timeout expected done seen hang");
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // enabled word for one cycle, then the start word; waits a few cycles for an answer
   task automatic start_homing();
      int n;
      n = 0;
      control_word = HMS_CW_ENABLED;
      @(negedge clk);
      control_word = HMS_CW_START;
      while (busy !== 1'b1 && err !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
   endtask
   // place the carriage, let the pin filters settle, then home and wait for the stop
   task automatic run_row(input hms_tb_row_t r);
      int n;
      n = 0;
      cfg.method = r.method;
      control_word = 8'h00;
      load = 1'b1;
      load_pos = r.start;
      repeat (8) @(negedge clk);
      load = 1'b0;
      start_homing();
      check("first dir", {31'h0, cmd.dir_pos}, {31'h0, r.dir0});
      check("first speed", cmd.speed, r.fast0 ? cfg.high_speed : cfg.low_speed);
      while (done !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      check("done", {busy, cmd.run, err, done}, 32'h1);
      check("stop speed", cmd.speed, 32'h0);
      check("stop window", {31'h0, pos >= win_lo[r.win] && pos <= win_hi[r.win]}, 32'h1);
      $display("case method %0d from %0d stopped at %0d", r.method, r.start, pos);
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      load = 1'b0;
      load_pos = '0;
      control_word = 8'h00;
      cfg = '{method: 4'h0, high_speed: 32'h4, low_speed: 32'h1, decel: 32'h10};
      repeat (20) @(negedge clk);
      check("reset outputs", {cmd.run, busy, done, err, cmd.speed[27:0]}, 32'h0);
      rst = 1'b0;
      $display("reset test finished");
      foreach (rows[i]) run_row(rows[i]);
      // start word without the enabled step before it is ignored
      control_word = 8'h00;
      repeat (2) @(negedge clk);
      control_word = HMS_CW_START;
      repeat (6) @(negedge clk);
      check("no start", {30'h0, busy, done}, 32'h1);
      $display("start order test finished");
      // unknown method code reports an error and does not move
      cfg.method = 4'hf;
      control_word = 8'h00;
      @(negedge clk);
      start_homing();
      check("bad method", {busy, cmd.run, err, done}, 32'h2);
      $display("bad method test finished");
      // drop the start bit mid-run: everything stops, no done
      cfg.method = HMS_M_HS_D;
      control_word = 8'h00;
      @(negedge clk);
      start_homing();
      repeat (10) @(negedge clk);
      check("decel pass", cmd.decel, cfg.decel);
      control_word = HMS_CW_ENABLED;
      repeat (3) @(negedge clk);
      check("abort", {busy, cmd.run, err, done}, 32'h0);
      check("abort speed", cmd.speed, 32'h0);
      $display("abort test finished");
      // reset in mid-run clears every output
      control_word = 8'h00;
      @(negedge clk);
      start_homing();
      repeat (5) @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      check("mid reset", {cmd.run, busy, done, err, cmd.speed[27:0]}, 32'h0);
      rst = 1'b0;
      // start word still applied, but no enabled step since reset: stay idle
      repeat (2) @(negedge clk);
      check("after reset", {busy, cmd.run, done, err}, 32'h0);
      $display("mid-run reset test finished");
      end_of_test();
   end
endmodule
`default_nettype wire
